// *** rtl/pwrmc_top.sv ***
// Power mode controller with APB register access
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/1ps
module pwrmc_top
    import pwrmc_pkg::*;
(
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        nrst,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Wake sources
    input  wire logic        irq_any,
    input  wire logic        irq_ext,
    // Clock gating controls and serial rate bit
    output logic             cpu_clk_en,
    output logic             periph_clk_en,
    output logic             serial_rate_double
);
    // Mode state and control register
    pwrmc_state_t state;
    logic [7:0]   power_control;

    // Wake levels before and after synchronising
    logic [1:0]   irq_raw;
    logic [1:0]   irq_sync;
    logic         any_s2;
    logic         ext_s2;

    // Bus decode
    logic         access;
    logic         hit_pc;
    logic         hit_status;
    logic         wr_pc;

    // Wake conditions
    logic         wake_idle;
    logic         wake_pd;

    // Exact match on all 12 bits of the byte address
    function automatic logic addr_hit(input logic [11:0] addr,
                                      input logic [11:0] target);
        return (addr == target);
    endfunction

    // Interrupt levels come from outside; two flops each
    assign irq_raw = {irq_ext, irq_any};

    for (genvar i = 0; i < 2; i++) begin : g_sync
        logic s1;
        logic s2;

        always_ff @(posedge mclk or negedge nrst) begin
            if (!nrst) begin
                s1 <= 1'b0;
                s2 <= 1'b0;
            end else begin
                s1 <= irq_raw[i];
                s2 <= s1;
            end
        end

        assign irq_sync[i] = s2;
    end

    assign any_s2 = irq_sync[0];
    assign ext_s2 = irq_sync[1];

    // First access cycle only; the answer cycle is not taken again
    assign access     = psel && penable && !pready;
    assign hit_pc     = addr_hit(paddr, POWER_CONTROL_ADDR);
    assign hit_status = addr_hit(paddr, STATUS_ADDR[11:0]);
    assign wr_pc      = access && pwrite && hit_pc;

    // Idle ends on any interrupt, power-down on external only
    assign wake_idle = (state == PWRMC_IDLE) && (any_s2 || ext_s2);
    assign wake_pd   = (state == PWRMC_PD) && ext_s2;

    // Mode sequencing
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            state <= PWRMC_RUN;
        end else begin
            case (state)
                PWRMC_RUN: begin
                    if (power_control[BIT_PD_REQ]) begin
                        state <= PWRMC_PD;
                    end else if (power_control[BIT_IDLE_REQ]) begin
                        state <= PWRMC_IDLE;
                    end
                end
                PWRMC_IDLE: begin
                    if (power_control[BIT_PD_REQ]) begin
                        state <= PWRMC_PD;
                    end else if (wake_idle) begin
                        state <= PWRMC_RUN;
                    end
                end
                PWRMC_PD: begin
                    if (wake_pd) begin
                        state <= PWRMC_RUN;
                    end
                end
                default: state <= PWRMC_RUN;
            endcase
        end
    end

    // Control register; idle and power-down request bits cleared on wake
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            power_control <= POWER_CONTROL_RST;
        end else if (wake_idle || wake_pd) begin
            power_control[BIT_IDLE_REQ] <= 1'b0;
            power_control[BIT_PD_REQ]   <= 1'b0;
        end else if (wr_pc) begin
            power_control <= pwdata[7:0] & POWER_CONTROL_MASK;
        end
    end

    // CPU clock runs only in run mode, back on at the wake edge
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            cpu_clk_en <= 1'b1;
        end else begin
            cpu_clk_en <= (state == PWRMC_RUN) || wake_idle || wake_pd;
        end
    end

    // Peripherals stop only in power-down
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            periph_clk_en <= 1'b1;
        end else begin
            periph_clk_en <= (state != PWRMC_PD) || wake_pd;
        end
    end

    // Serial rate bit is only passed on to the serial port
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            serial_rate_double <= 1'b0;
        end else begin
            serial_rate_double <= power_control[BIT_SERIAL_DBL];
        end
    end

    // APB answer, one wait state
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            pready <= 1'b0;
        end else begin
            pready <= access;
        end
    end

    // Unmapped words answer with an error
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            pslverr <= 1'b0;
        end else begin
            pslverr <= access && !hit_pc && !hit_status;
        end
    end

    // Read data stands only in the answer cycle
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            prdata <= 32'h0000_0000;
        end else if (access && hit_pc) begin
            prdata <= {24'h000000, power_control};
        end else if (access && hit_status) begin
            prdata <= {30'h00000000, state};
        end else begin
            prdata <= 32'h0000_0000;
        end
    end
endmodule // pwrmc_top

// *** pkg/pwrmc_pkg.sv ***
// Constants and types for the power mode control block
// Function
// - Idle request gates CPU clock only
// - Any interrupt or reset ends idle
// - Power-down request stops CPU and peripherals
// - Only reset or external interrupt ends power-down
// - Bits 3 and 2 are plain user flags
package pwrmc_pkg;
    localparam logic [11:0] POWER_CONTROL_IDX  = 12'h087;
    localparam logic [11:0] POWER_CONTROL_ADDR = 12'h21c;
    localparam logic [7:0]  POWER_CONTROL_RST  = 8'h00;
    localparam int          BIT_IDLE_REQ       = 0;
    localparam int          BIT_PD_REQ         = 1;
    localparam int          BIT_FLAG_LO        = 2;
    localparam int          BIT_FLAG_HI        = 3;
    localparam int          BIT_SERIAL_DBL     = 7;
    localparam logic [7:0]  POWER_CONTROL_MASK = 8'h8f;
    localparam logic [31:0] STATUS_ADDR        = 32'h0000_0220;

    typedef enum logic [1:0] {
        PWRMC_RUN  = 2'b00,
        PWRMC_IDLE = 2'b01,
        PWRMC_PD   = 2'b11
    } pwrmc_state_t;
endpackage

// *** sim/pwrmc_chk.sv ***
// Checker for the power mode controller ports
`timescale 1ns/1ps
module pwrmc_chk
    import pwrmc_pkg::*;
(
    input wire logic mclk, nrst, psel, penable, pwrite, pready,
    input wire logic irq_any, irq_ext, cpu_clk_en, periph_clk_en,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!nrst);
    wire logic wr = psel & penable & pready & pwrite & (paddr == POWER_CONTROL_ADDR);
    AST_IDLE: assert property (wr && pwdata[1:0] == 2'h1 && !irq_any && !irq_ext
        |-> ##[1:3] !cpu_clk_en && periph_clk_en) else $error("idle entry");
    AST_WAKE: assert property (!cpu_clk_en && periph_clk_en && irq_any
        |-> ##[1:4] cpu_clk_en) else $error("idle wake");
    AST_PD: assert property (wr && pwdata[1] && !irq_ext |-> ##[1:3] !periph_clk_en)
        else $error("pd entry");
    AST_BOTH: assert property (!periph_clk_en |-> !cpu_clk_en) else $error("pd cpu");
    AST_HOLD: assert property ((!periph_clk_en && !irq_ext)[*3] |=> !periph_clk_en)
        else $error("pd left");
    AST_EXIT: assert property (!periph_clk_en && irq_ext
        |-> ##[1:4] cpu_clk_en && periph_clk_en) else $error("pd wake");
    AST_PREC: assert property (wr && pwdata[1:0] == 2'h3 && !irq_ext
        |-> ##[1:3] !cpu_clk_en && !periph_clk_en) else $error("pd precedence");
    cover property (wr && pwdata[1:0] == 2'h3);
    cover property ($fell(cpu_clk_en) && periph_clk_en);
    cover property ($rose(periph_clk_en));
endmodule // pwrmc_chk
bind pwrmc_top pwrmc_chk u_chk (.*);

// *** sim/tb_power_mode_control.sv ***
// Testbench for the power mode controller
`timescale 1ns/1ps
module tb_power_mode_control;
    logic mclk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0, irq_any = 0, irq_ext = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic pready, pslverr, cpu_clk_en, periph_clk_en, serial_rate_double, err;
    int failures = 0, n_compared = 0;
    always #2.5 mclk = ~mclk;
    pwrmc_top u_dut (.mclk(mclk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .irq_any(irq_any), .irq_ext(irq_ext), .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en),
        .serial_rate_double(serial_rate_double));
    task end_sim;
        $display("compared %0d mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task chk(input logic [31:0] g, e);
        n_compared++;
        if (g !== e) begin
            failures++;
            $display("mismatch at %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge mclk) {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge mclk) penable <= 1;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1 && n < 20);
        chk(pready, 1);
        if (pready !== 1) end_sim;
        {rd, err} = {prdata, pslverr};
        {psel, penable} <= 2'b0;
    endtask
    task wake;
        repeat (20) if (cpu_clk_en !== 1) @(negedge mclk);
        chk({cpu_clk_en, periph_clk_en}, 2'b11);
        if (cpu_clk_en !== 1) end_sim;
    endtask
    task t_regs;
        apb(0, 12'h21c, 0);
        chk(rd, 0);
        apb(0, 12'h220, 0);
        chk(rd, 0);
        apb(1, 12'h21c, 32'hfc);
        apb(0, 12'h21c, 0);
        chk(rd, 32'h8c);
        chk({serial_rate_double, cpu_clk_en, periph_clk_en}, 3'b111);
        apb(0, 12'h300, 0);
        chk(err, 1);
        $display("regs end");
    endtask
    task t_idle;
        apb(1, 12'h21c, 32'h8d);
        repeat (4) @(negedge mclk);
        chk({cpu_clk_en, periph_clk_en}, 2'b01);
        apb(0, 12'h220, 0);
        chk(rd, 1);
        @(posedge mclk) irq_any <= 1;
        wake;
        @(posedge mclk) irq_any <= 0;
        apb(0, 12'h21c, 0);
        chk(rd, 32'h8c);
        $display("idle end");
    endtask
    task t_pd;
        apb(1, 12'h21c, 32'h3);
        repeat (4) @(negedge mclk);
        chk({cpu_clk_en, periph_clk_en}, 2'b00);
        apb(0, 12'h220, 0);
        chk(rd, 3);
        @(posedge mclk) irq_any <= 1;
        repeat (8) @(negedge mclk);
        chk(periph_clk_en, 0);
        @(posedge mclk) irq_ext <= 1;
        wake;
        @(posedge mclk) {irq_any, irq_ext} <= 2'b0;
        apb(0, 12'h21c, 0);
        chk(rd, 0);
        $display("pd end");
    endtask
    task t_rst(input logic [31:0] req, input logic [1:0] en);
        apb(1, 12'h21c, req);
        repeat (4) @(negedge mclk);
        chk({cpu_clk_en, periph_clk_en}, en);
        @(posedge mclk) nrst <= 0;
        repeat (2) @(posedge mclk);
        nrst <= 1;
        @(negedge mclk) chk({cpu_clk_en, periph_clk_en}, 2'b11);
        apb(0, 12'h21c, 0);
        chk(rd, 0);
        $display("reset exit end");
    endtask
    initial begin
        repeat (4) @(posedge mclk);
        nrst <= 1;
        t_regs;
        t_idle;
        t_pd;
        t_rst(32'h1, 2'b01);
        t_rst(32'h2, 2'b00);
        end_sim;
    end
endmodule // tb_power_mode_control
